// [rtl/adctrg_pkg.sv]
package adctrg_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0] ADR_CTRL1      = 4'h0;
  localparam logic [3:0] ADR_CTRL3      = 4'h4;
  localparam logic [3:0] ADR_STATUS     = 4'h8;

  // first_control_register fields
  localparam int         POS_ON         = 15;
  localparam int         POS_SRC_HI     = 7;
  localparam int         POS_SRC_LO     = 5;
  localparam int         POS_AUTO_SAMPLE_ENABLE       = 2;
  localparam int         POS_SAMPLE_CONTROL       = 1;
  localparam int         POS_CONV       = 0;
  localparam int         POS_EDGE       = 8;
  // third_control_register fields
  localparam int         POS_SMT_HI     = 12;
  localparam int         POS_SMT_LO     = 8;
  localparam int         POS_DIV_HI     = 5;
  localparam int         POS_DIV_LO     = 0;
  // status register fields
  localparam int         POS_DONE       = 0;

  localparam logic [2:0] SRC_SOFT       = 3'h0;
  localparam logic [2:0] SRC_PIN        = 3'h1;
  localparam logic [2:0] SRC_TIMER      = 3'h2;
  localparam logic [2:0] SRC_PWM        = 3'h3;
  localparam logic [2:0] SRC_CLOCKED    = 3'h7;

  localparam logic [4:0] RST_SMT        = 5'h00;
  localparam logic [5:0] RST_DIV        = 6'h00;
  // conversion length in conversion-clock periods
  localparam logic [4:0] CONV_TAD       = 5'h0E;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adctrg_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [3:0]  adr;
    logic [31:0] dat;
  } adctrg_wb_req_t;

  typedef struct packed {
    logic        ext_pin;
    logic        timer_match;
    logic        pwm_event;
  } adctrg_trig_t;

endpackage

// [rtl/adctrg_top.sv]
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
module adctrg_top
  import adctrg_pkg::*;
(
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // wishbone slave
  input  wire adctrg_pkg::adctrg_wb_req_t wb_req_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o,
  // trigger events
  input  wire adctrg_pkg::adctrg_trig_t   trig_i,
  // converter handshake
  output logic                            conv_start_o,
  output logic                            sampling_o,
  output logic                            converting_o
);
  import adctrg_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic          on_ff, auto_sample_enable_ff, edge_ff, sample_control_ff, done_ff;
  logic [2:0]    src_ff;
  logic [4:0]    smt_ff, cnt_ff;
  logic [5:0]    div_ff, dcnt_ff;
  adctrg_state_t st_ff;
  logic [2:0]    pin_hist_ff, tmr_hist_ff, pwm_hist_ff;
  logic          ack_ff, start_ff, conv_ff, nxt_conv;
  logic [31:0]   rdat_ff;

  logic          nxt_on, nxt_auto_sample_enable, nxt_edge, nxt_sample_control, nxt_done, nxt_ack, nxt_start;
  logic [2:0]    nxt_src;
  logic [4:0]    nxt_smt, nxt_cnt;
  logic [5:0]    nxt_div, nxt_dcnt;
  adctrg_state_t nxt_st;
  logic [31:0]   nxt_rdat;

  logic          wr, rd_ack, tad, pin_ev, tmr_ev, pwm_ev, trig, sample_control_clr;
  logic [31:0]   ctrl1_val, ctrl3_val, stat_val;

  // ************************************************************
  // event synchronisers
  // ************************************************************
  // bit 0 is the meta stage; edges are judged on bits 2:1 only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_hist_ff <= 3'h0;
      tmr_hist_ff <= 3'h0;
      pwm_hist_ff <= 3'h0;
    end
    else
    begin
      pin_hist_ff <= {pin_hist_ff[1:0], trig_i.ext_pin};
      tmr_hist_ff <= {tmr_hist_ff[1:0], trig_i.timer_match};
      pwm_hist_ff <= {pwm_hist_ff[1:0], trig_i.pwm_event};
    end
  end

  // rising pin edge, or falling edge when edge_ff is set, one pulse each
  assign pin_ev = edge_ff ? (pin_hist_ff[2] & ~pin_hist_ff[1])
                          : (~pin_hist_ff[2] & pin_hist_ff[1]);
  assign tmr_ev = ~tmr_hist_ff[2] & tmr_hist_ff[1];
  assign pwm_ev = ~pwm_hist_ff[2] & pwm_hist_ff[1];

  // ************************************************************
  // bus decode
  // ************************************************************
  assign wr     = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~ack_ff;
  assign rd_ack = wb_req_i.cyc & wb_req_i.stb & ~ack_ff;

  assign ctrl1_val = {16'h0000, on_ff, 6'h00, edge_ff, src_ff, 2'h0, auto_sample_enable_ff,
                      sample_control_ff, conv_ff};
  assign ctrl3_val = {19'h00000, smt_ff, 2'h0, div_ff};
  assign stat_val  = {31'h00000000, done_ff};

  // ************************************************************
  // control next state
  // ************************************************************
  always_comb
  begin
    nxt_on    = on_ff;
    nxt_auto_sample_enable  = auto_sample_enable_ff;
    nxt_edge  = edge_ff;
    nxt_src   = src_ff;
    nxt_smt   = smt_ff;
    nxt_div   = div_ff;
    nxt_sample_control  = sample_control_ff;
    nxt_done  = done_ff;
    nxt_cnt   = cnt_ff;
    nxt_dcnt  = dcnt_ff;
    nxt_st    = st_ff;
    nxt_start = 1'b0;
    nxt_ack   = rd_ack;
    nxt_rdat  = 32'h00000000;
    sample_control_clr  = 1'b0;
    tad       = 1'b0;
    trig      = 1'b0;

    if (rd_ack && !wb_req_i.we)
    begin
      if (wb_req_i.adr == ADR_CTRL1)
        nxt_rdat = ctrl1_val;
      else if (wb_req_i.adr == ADR_CTRL3)
        nxt_rdat = ctrl3_val;
      else if (wb_req_i.adr == ADR_STATUS)
        nxt_rdat = stat_val;
      else
        nxt_rdat = 32'h00000000;
    end

    if (wr && wb_req_i.adr == ADR_CTRL1)
    begin
      if (wb_req_i.sel[0])
      begin
        nxt_src  = wb_req_i.dat[POS_SRC_HI:POS_SRC_LO];
        nxt_auto_sample_enable = wb_req_i.dat[POS_AUTO_SAMPLE_ENABLE];
        nxt_sample_control = wb_req_i.dat[POS_SAMPLE_CONTROL];
        sample_control_clr = sample_control_ff & ~wb_req_i.dat[POS_SAMPLE_CONTROL];
      end
      if (wb_req_i.sel[1])
      begin
        nxt_on   = wb_req_i.dat[POS_ON];
        nxt_edge = wb_req_i.dat[POS_EDGE];
      end
    end
    else if (wr && wb_req_i.adr == ADR_CTRL3)
    begin
      if (wb_req_i.sel[0])
        nxt_div = wb_req_i.dat[POS_DIV_HI:POS_DIV_LO];
      if (wb_req_i.sel[1])
        nxt_smt = wb_req_i.dat[POS_SMT_HI:POS_SMT_LO];
    end
    else if (wr && wb_req_i.adr == ADR_STATUS && wb_req_i.sel[0] && wb_req_i.dat[POS_DONE])
      nxt_done = 1'b0;

    // conversion-clock enable from the divider
    if (on_ff)
    begin
      if (dcnt_ff >= div_ff)
      begin
        nxt_dcnt = 6'h00;
        tad      = 1'b1;
      end
      else
        nxt_dcnt = dcnt_ff + 6'h01;
    end
    else
      nxt_dcnt = 6'h00;

    case (src_ff)
      SRC_SOFT:    trig = sample_control_clr;
      SRC_PIN:     trig = pin_ev;
      SRC_TIMER:   trig = tmr_ev;
      SRC_PWM:     trig = pwm_ev;
      SRC_CLOCKED: trig = tad && (cnt_ff + 5'h01 >= smt_ff);
      default:     trig = 1'b0;
    endcase

    case (st_ff)
      ST_IDLE:
      begin
        if (on_ff && (nxt_sample_control || auto_sample_enable_ff))
        begin
          nxt_st   = ST_SAMPLE;
          nxt_sample_control = 1'b1;
          nxt_cnt  = 5'h00;
        end
      end
      ST_SAMPLE:
      begin
        if (tad)
          nxt_cnt = cnt_ff + 5'h01;
        if (trig)
        begin
          nxt_st    = ST_CONVERT;
          nxt_sample_control  = 1'b0;
          nxt_start = 1'b1;
          nxt_cnt   = 5'h00;
        end
        else if (!nxt_sample_control)
          nxt_st = ST_IDLE;
      end
      ST_CONVERT:
      begin
        nxt_sample_control = 1'b0;
        if (tad)
          nxt_cnt = cnt_ff + 5'h01;
        if (tad && cnt_ff + 5'h01 >= CONV_TAD)
        begin
          nxt_done = 1'b1;
          nxt_cnt  = 5'h00;
          if (auto_sample_enable_ff)
          begin
            nxt_st   = ST_SAMPLE;
            nxt_sample_control = 1'b1;
          end
          else
            nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase

    // turning off aborts any sequence
    if (!nxt_on)
    begin
      nxt_st   = ST_IDLE;
      nxt_sample_control = 1'b0;
    end
    // registered so the status output comes straight from a flop
    nxt_conv = (nxt_st == ST_CONVERT);
  end

  // ************************************************************
  // registering
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      on_ff    <= 1'b0;
      auto_sample_enable_ff  <= 1'b0;
      edge_ff  <= 1'b0;
      src_ff   <= SRC_SOFT;
      smt_ff   <= RST_SMT;
      div_ff   <= RST_DIV;
      sample_control_ff  <= 1'b0;
      done_ff  <= 1'b0;
      cnt_ff   <= 5'h00;
      dcnt_ff  <= 6'h00;
      st_ff    <= ST_IDLE;
      start_ff <= 1'b0;
      conv_ff  <= 1'b0;
      ack_ff   <= 1'b0;
      rdat_ff  <= 32'h00000000;
    end
    else
    begin
      on_ff    <= nxt_on;
      auto_sample_enable_ff  <= nxt_auto_sample_enable;
      edge_ff  <= nxt_edge;
      src_ff   <= nxt_src;
      smt_ff   <= nxt_smt;
      div_ff   <= nxt_div;
      sample_control_ff  <= nxt_sample_control;
      done_ff  <= nxt_done;
      cnt_ff   <= nxt_cnt;
      dcnt_ff  <= nxt_dcnt;
      st_ff    <= nxt_st;
      start_ff <= nxt_start;
      conv_ff  <= nxt_conv;
      ack_ff   <= nxt_ack;
      rdat_ff  <= nxt_rdat;
    end
  end

  assign wb_ack_o     = ack_ff;
  assign wb_dat_o     = rdat_ff;
  assign conv_start_o = start_ff;
  assign sampling_o   = sample_control_ff;
  assign converting_o = conv_ff;

  // ************************************************************
  // checks
  // ************************************************************
  property p_manual;
    @(posedge clk_i) disable iff (rst_i)
      (st_ff == ST_SAMPLE && src_ff == SRC_SOFT && sample_control_clr && on_ff) |=> conv_start_o;
  endproperty
  a_manual: assert property (p_manual) else $error("manual clear did not convert");

  property p_auto;
    @(posedge clk_i) disable iff (rst_i)
      (st_ff == ST_CONVERT && nxt_done && !done_ff && auto_sample_enable_ff && nxt_on) |=> sampling_o;
  endproperty
  a_auto: assert property (p_auto) else $error("auto sample did not resume");

  property p_clocked;
    @(posedge clk_i) disable iff (rst_i)
      (conv_start_o && src_ff == SRC_CLOCKED) |-> $past(cnt_ff) + 5'h01 >= smt_ff;
  endproperty
  a_clocked: assert property (p_clocked) else $error("clocked trigger too early");

  property p_pin;
    @(posedge clk_i) disable iff (rst_i)
      (pin_ev && src_ff == SRC_PIN && st_ff == ST_SAMPLE && on_ff) |=> conv_start_o;
  endproperty
  a_pin: assert property (p_pin) else $error("pin edge missed");

  property p_timer;
    @(posedge clk_i) disable iff (rst_i)
      (tmr_ev && src_ff == SRC_TIMER && st_ff == ST_SAMPLE && on_ff) |=> conv_start_o;
  endproperty
  a_timer: assert property (p_timer) else $error("timer match missed");

  property p_pwm;
    @(posedge clk_i) disable iff (rst_i)
      (pwm_ev && src_ff == SRC_PWM && st_ff == ST_SAMPLE && on_ff) |=> conv_start_o;
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm event missed");

  property p_pulse;
    @(posedge clk_i) disable iff (rst_i)
      conv_start_o |=> !conv_start_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than a cycle");

  property p_excl;
    @(posedge clk_i) disable iff (rst_i)
      converting_o |-> !sampling_o;
  endproperty
  a_excl: assert property (p_excl) else $error("sampling during conversion");

  property p_src;
    @(posedge clk_i) disable iff (rst_i)
      (wr && wb_req_i.adr == ADR_CTRL1 && wb_req_i.sel[0])
        |=> src_ff == $past(wb_req_i.dat[POS_SRC_HI:POS_SRC_LO]);
  endproperty
  a_src: assert property (p_src) else $error("source field not stored");

  property p_free;
    @(posedge clk_i) disable iff (rst_i)
      (converting_o && src_ff == SRC_CLOCKED && auto_sample_enable_ff && on_ff && tad
        && cnt_ff + 5'h01 >= CONV_TAD && nxt_on) |=> sampling_o;
  endproperty
  a_free: assert property (p_free) else $error("free run stopped");

endmodule

// [sim/adctrg_partner.sv]
`timescale 1ns/1ps
// ****************************************
// trigger sources on the far side
// ****************************************
module adctrg_partner
  import adctrg_pkg::*;
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // command from the bench
  input  wire logic               go_i,
  input  wire logic [1:0]         kind_i,
  // events
  output adctrg_pkg::adctrg_trig_t trig_o
);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig_o <= '0;
    end
    else
    begin
      // match events last one cycle, as a real compare would
      trig_o.timer_match <= go_i && (kind_i == 2'h1);
      trig_o.pwm_event   <= go_i && (kind_i == 2'h2);
      // pin toggles, so one level change is one edge
      if (go_i && (kind_i == 2'h0))
      begin
        trig_o.ext_pin <= ~trig_o.ext_pin;
      end
    end
  end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module testbench;
  import adctrg_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic           clk_i = 1'b0;
  logic           rst_i = 1'b1;
  adctrg_wb_req_t req   = '0;
  adctrg_trig_t   trig;
  logic [31:0]    wb_dat_o;
  logic           wb_ack_o;
  logic           conv_start_o;
  logic           sampling_o;
  logic           converting_o;
  logic           go    = 1'b0;
  logic [1:0]     kind  = 2'h0;
  logic [31:0]    q;
  int             bad_count = 0;
  int             checks    = 0;
  int             n;
  int             t2;
  int             starts    = 0;
  int             s0        = 0;
  typedef struct {logic [31:0] ctl; logic [1:0] k; logic e;} adctrg_row_t;
  adctrg_row_t    rows [7];
  always #50 clk_i = ~clk_i;
  // a soft start pulses while the bus task is still busy, so pulses are counted here
  always @(posedge clk_i)
    if (conv_start_o === 1'b1) starts <= starts + 1;
  adctrg_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .trig_i(trig), .conv_start_o(conv_start_o),
    .sampling_o(sampling_o), .converting_o(converting_o));
  adctrg_partner far (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .kind_i(kind), .trig_o(trig));
  // ****************************************
  // tasks
  // ****************************************
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    begin
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h3, adr: a, dat: d};
      k = 0;
      do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 20);
      q = wb_dat_o;
      req <= '0;
      if (k >= 20) bad_count++;
    end
  endtask
  // edges until a start pulse, limit+1 if none came
  task automatic wait_start(input int lim, output int c);
    begin
      c = 0;
      do begin @(posedge clk_i); c++; end while (starts == s0 && c <= lim);
    end
  endtask
  task automatic fire(input logic [1:0] k);
    begin
      @(posedge clk_i);
      go   <= 1'b1;
      kind <= k;
      @(posedge clk_i);
      go   <= 1'b0;
    end
  endtask
  task automatic print_verdict;
    begin
      if (bad_count == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    rows[0] = '{32'h8002, 2'h3, 1'b1};
    rows[1] = '{32'h8022, 2'h0, 1'b1};
    rows[2] = '{32'h8122, 2'h0, 1'b1};
    rows[3] = '{32'h8042, 2'h1, 1'b1};
    rows[4] = '{32'h8042, 2'h2, 1'b0};
    rows[5] = '{32'h8062, 2'h2, 1'b1};
    rows[6] = '{32'h8022, 2'h1, 1'b0};
    repeat (12) @(posedge clk_i);
    `CHK("start in reset", 1'b0, conv_start_o)
    rst_i <= 1'b0;
    wb(1'b0, ADR_CTRL1, '0);
    `CHK("ctrl1 reset", 32'h0, q)
    wb(1'b0, 4'hC, '0);
    `CHK("unmapped read", 32'h0, q)
    wb(1'b1, ADR_CTRL3, 32'h0);
    foreach (rows[i])
    begin
      wb(1'b1, ADR_CTRL1, rows[i].ctl & 32'h01E0);
      wb(1'b1, ADR_CTRL1, rows[i].ctl);
      // software holds sampling long enough before ending it
      repeat (5) @(posedge clk_i);
      s0 = starts;
      if (rows[i].k == 2'h3)
        wb(1'b1, ADR_CTRL1, rows[i].ctl & ~32'h2);
      else
        fire(rows[i].k);
      wait_start(10, n);
      `CHK("start seen", rows[i].e, n <= 10)
      @(negedge clk_i);
      `CHK("converting", rows[i].e, converting_o)
      `CHK("sampling", ~rows[i].e, sampling_o)
      s0 = starts;
      wait_start(3, n);
      `CHK("single start", 1'b1, n > 3)
      wb(1'b1, ADR_CTRL1, 32'h0);
    end
    // sample time of 2 and 6 periods must differ by exactly 4
    for (int s = 2; s <= 6; s += 4)
    begin
      wb(1'b1, ADR_CTRL3, s << 8);
      s0 = starts;
      wb(1'b1, ADR_CTRL1, 32'h00E0);
      wb(1'b1, ADR_CTRL1, 32'h80E2);
      wait_start(40, n);
      if (s == 2) t2 = n;
      wb(1'b1, ADR_CTRL1, 32'h0);
    end
    `CHK("sample count", 4, n - t2)
    // auto sampling with a software clear: one start must follow the clear
    wb(1'b1, ADR_CTRL1, 32'h0004);
    wb(1'b1, ADR_CTRL1, 32'h8006);
    repeat (5) @(posedge clk_i);
    s0 = starts;
    wb(1'b1, ADR_CTRL1, 32'h8004);
    wait_start(10, n);
    `CHK("soft auto start", 1'b1, n <= 10)
    wb(1'b1, ADR_CTRL1, 32'h0);
    // free running: clocked trigger with auto sampling
    s0 = starts;
    wb(1'b1, ADR_CTRL1, 32'h00E4);
    wb(1'b1, ADR_CTRL1, 32'h80E6);
    wait_start(40, n);
    n = 0;
    do begin @(posedge clk_i); n++; end while (converting_o !== 1'b0 && n < 60);
    @(negedge clk_i);
    `CHK("auto resample", 1'b1, sampling_o)
    s0 = starts;
    wait_start(60, n);
    `CHK("free run start", 1'b1, n <= 60)
    wb(1'b0, ADR_STATUS, '0);
    `CHK("done flag", 1'b1, q[POS_DONE])
    wb(1'b1, ADR_CTRL1, 32'h0);
    print_verdict();
  end
endmodule
